/* File: hdl/rtc_clkdiv.sv */
// Oscillator divider that produces the raw clock and square-wave outputs.
`timescale 1ns/1ps
module rtc_clkdiv
  import rtc_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_osc_clk,
  input  wire logic       i_run,
  input  wire logic       i_raw_en,
  input  wire logic [3:0] i_raw_sel,
  input  wire logic [2:0] i_sqw_sel,
  output logic            o_raw_pin,
  output logic            o_raw_oe,
  output logic            o_sqw_pin
);

  logic [2:0]       osc_sync_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] sqw_cnt_q;
  logic             osc_rise;
  logic             raw_d;

  // Half period in oscillator ticks; not an exact binary fraction, so the half period is truncated.
  function automatic logic [DIV_W-1:0] sqw_half(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > SQW_MAX_CODE) ? SQW_MAX_CODE : sel;
    sqw_half = DIV_W'((OSC_HZ / 2) >> s);
  endfunction

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      osc_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], i_osc_clk};
    end
  end

  assign osc_rise = osc_sync_q[1] & ~osc_sync_q[2];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_run) begin
      div_q <= '0;
    end else if (osc_rise) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_comb begin
    if (i_raw_sel >= RAW_FULL_RATE_CODE) begin
      raw_d = osc_sync_q[1];
    end else begin
      raw_d = div_q[DIV_W - 1 - int'(i_raw_sel)];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_raw_pin <= 1'b0;
      o_raw_oe  <= 1'b0;
    end else begin
      o_raw_pin <= raw_d & i_run;
      o_raw_oe  <= i_raw_en;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_run) begin
      sqw_cnt_q <= '0;
      o_sqw_pin <= 1'b0;
    end else if (osc_rise) begin
      if (sqw_cnt_q >= sqw_half(i_sqw_sel) - 1'b1) begin
        sqw_cnt_q <= '0;
        o_sqw_pin <= ~o_sqw_pin;
      end else begin
        sqw_cnt_q <= sqw_cnt_q + 1'b1;
      end
    end
  end

endmodule

/* File: hdl/rtc_ctl_top.sv */
// Control and configuration register bank with its serial bus slave and interrupt pin.
`timescale 1ns/1ps
module rtc_ctl_top
  import rtc_pkg::*;
#(
  // Bus address value is arbitrary.
  parameter logic [6:0]  DEV_ADDR       = 7'h2a,
  parameter int unsigned TIMEOUT_CYCLES = I2C_TIMEOUT_MS * (CLK_HZ / 1000)
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda,
  output logic      o_sda_oe,
  input  wire logic i_osc_clk,
  input  wire logic i_power_fail,
  input  wire logic i_temp_ready,
  input  wire logic i_countdown_expired,
  input  wire logic i_alarm_two,
  input  wire logic i_alarm_one,
  output logic      o_int_n,
  output logic      o_raw_clock_pin,
  output logic      o_raw_clock_oe,
  output logic      o_square_wave_pin,
  output logic      o_retention_mode,
  output logic      o_i2c_timeout_en,
  output logic      o_oscillator_en,
  output logic      o_digital_reset
);

  localparam int TMO_W = 23;
  localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(TIMEOUT_CYCLES - 1);

  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << TMO_W)) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  logic [2:0]     scl_sync_q;
  logic [2:0]     sda_sync_q;
  logic [1:0]     power_fail_flag_sync_q;
  logic           scl_s;
  logic           sda_s;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  logic [TMO_W-1:0] tmo_cnt_q;
  logic           tmo_hit;

  rtc_i2c_state_t state_q;
  logic [7:0]     shift_q;
  logic [3:0]     bit_cnt_q;
  logic [7:0]     ptr_q;
  logic           ptr_ok_q;
  logic           rw_q;
  logic           nack_q;
  logic           sda_oe_q;
  logic           load_now;
  logic           wr_stb_q;
  logic [7:0]     wr_addr_q;
  logic [7:0]     wr_data_q;
  logic           rd_clr_q;
  logic [7:0]     rd_data;

  logic [7:0]     int_en_q;
  logic           soft_rst_q;
  logic [7:0]     core_cfg_q;
  logic [7:0]     clk_cfg_q;
  logic [7:0]     status_q;
  logic [7:0]     flag_set;
  logic           osc_run;
  logic           osc_en_q;
  logic           int_n_q;

  // Both bus lines are asynchronous to the system clock; only the second and third stages are used.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scl_sync_q   <= 3'h7;
      sda_sync_q   <= 3'h7;
      power_fail_flag_sync_q <= 2'h0;
    end else begin
      scl_sync_q   <= {scl_sync_q[1:0], i_scl};
      sda_sync_q   <= {sda_sync_q[1:0], i_sda};
      power_fail_flag_sync_q <= {power_fail_flag_sync_q[0], i_power_fail};
    end
  end

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign scl_rise  = scl_s & ~scl_sync_q[2];
  assign scl_fall  = ~scl_s & scl_sync_q[2];
  assign start_det = scl_s & scl_sync_q[2] & sda_sync_q[2] & ~sda_s;
  assign stop_det  = scl_s & scl_sync_q[2] & ~sda_sync_q[2] & sda_s;

  // A master that stalls with the clock low would otherwise lock the slave up.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || state_q == ST_IDLE || scl_s) begin
      tmo_cnt_q <= '0;
    end else if (tmo_cnt_q != TMO_LIMIT) begin
      tmo_cnt_q <= tmo_cnt_q + 1'b1;
    end
  end

  assign tmo_hit = core_cfg_q[BIT_I2C_TIMEOUT] && (tmo_cnt_q == TMO_LIMIT);

  // A read byte is fetched at the falling edge that ends an acknowledge.
  assign load_now = scl_fall && ((state_q == ST_ACK && rw_q) || (state_q == ST_RACK && !nack_q));

  always_ff @(posedge i_clk_sys) begin
    wr_stb_q <= 1'b0;
    rd_clr_q <= 1'b0;
    if (!i_rst_n) begin
      state_q   <= ST_IDLE;
      shift_q   <= 8'h00;
      bit_cnt_q <= 4'h0;
      ptr_q     <= 8'h00;
      ptr_ok_q  <= 1'b0;
      rw_q      <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (stop_det || tmo_hit) begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      ptr_ok_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (load_now) begin
      shift_q   <= rd_data;
      sda_oe_q  <= ~rd_data[BYTE_BITS-1];
      ptr_q     <= ptr_q + 1'b1;
      rd_clr_q  <= (ptr_q == ADDR_STATUS);
      bit_cnt_q <= 4'h1;
      state_q   <= ST_TX;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (scl_fall && bit_cnt_q == 4'(BYTE_BITS)) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              rw_q     <= shift_q[0];
              sda_oe_q <= 1'b1;
              state_q  <= ST_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= ST_RX;
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end else if (scl_fall && bit_cnt_q == 4'(BYTE_BITS)) begin
            if (!ptr_ok_q) begin
              ptr_q    <= shift_q;
              ptr_ok_q <= 1'b1;
            end else begin
              wr_stb_q  <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= shift_q;
              ptr_q     <= ptr_q + 1'b1;
            end
            sda_oe_q <= 1'b1;
            state_q  <= ST_ACK;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'(BYTE_BITS)) begin
              sda_oe_q <= 1'b0;
              nack_q   <= 1'b1;
              state_q  <= ST_RACK;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              sda_oe_q  <= ~shift_q[6];
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end else if (scl_fall) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (ptr_q)
      ADDR_STATUS:     rd_data = status_q;
      ADDR_INT_EN:     rd_data = int_en_q;
      ADDR_SOFT_RESET: rd_data = {7'h00, soft_rst_q};
      ADDR_CORE_CFG:   rd_data = core_cfg_q;
      ADDR_CLK_CFG:    rd_data = clk_cfg_q;
      default:         rd_data = 8'h00;
    endcase
  end

  // The reset bit itself must survive its own effect, so it has a register of its own.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      soft_rst_q <= 1'b0;
    end else if (wr_stb_q && wr_addr_q == ADDR_SOFT_RESET) begin
      soft_rst_q <= wr_data_q[BIT_SOFT_RESET];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || soft_rst_q) begin
      int_en_q   <= INT_EN_RST;
      core_cfg_q <= CORE_CFG_RST;
      clk_cfg_q  <= CLK_CFG_RST;
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        ADDR_INT_EN:   int_en_q   <= wr_data_q & INT_EN_MASK;
        // The reserved bits are cleared by the mask; only bits 0, 1, 3 and 4 are stored.
        ADDR_CORE_CFG: core_cfg_q <= wr_data_q & CORE_CFG_MASK;
        ADDR_CLK_CFG:  clk_cfg_q  <= wr_data_q;
        default:       int_en_q   <= int_en_q;
      endcase
    end
  end

  assign osc_run = core_cfg_q[BIT_OSC_EN] & ~soft_rst_q;

  always_comb begin
    flag_set                = 8'h00;
    flag_set[BIT_OSC_FLAG]  = ~osc_run;
    flag_set[BIT_POWER_FAIL_FLAG]     = power_fail_flag_sync_q[1];
    flag_set[BIT_TEMP]      = i_temp_ready;
    flag_set[BIT_CNTDN]     = i_countdown_expired;
    flag_set[BIT_ALM2]      = i_alarm_two;
    flag_set[BIT_ALM1]      = i_alarm_one;
  end

  // A source that fires in the cycle of the clearing read stays latched.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || soft_rst_q) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= (status_q & ~(rd_clr_q ? STATUS_FLAGS : 8'h00)) | flag_set;
      if (int_en_q[BIT_OSC_FLAG]) begin
        status_q[BIT_OSC_FLAG] <= 1'b0;
      end
    end
  end

  // The mask leaves the oscillator-stop bit out, so that flag can never reach the pin.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~|(status_q & int_en_q & IRQ_SRC_MASK);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      osc_en_q <= 1'b0;
    end else begin
      osc_en_q <= osc_run;
    end
  end

  rtc_clkdiv u_clkdiv (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_osc_clk (i_osc_clk),
    .i_run     (osc_run),
    .i_raw_en  (clk_cfg_q[BIT_RAW_EN]),
    .i_raw_sel (clk_cfg_q[RAW_FREQ_MSB:RAW_FREQ_LSB]),
    .i_sqw_sel (clk_cfg_q[SQW_FREQ_MSB:SQW_FREQ_LSB]),
    .o_raw_pin (o_raw_clock_pin),
    .o_raw_oe  (o_raw_clock_oe),
    .o_sqw_pin (o_square_wave_pin)
  );

  // Open-drain line: the pin is only ever pulled low, the enable carries the data.
  assign o_sda            = 1'b0;
  assign o_sda_oe         = sda_oe_q;
  assign o_int_n          = int_n_q;
  assign o_retention_mode = core_cfg_q[BIT_RETENTION];
  assign o_i2c_timeout_en = core_cfg_q[BIT_I2C_TIMEOUT];
  assign o_oscillator_en  = osc_en_q;
  assign o_digital_reset  = soft_rst_q;

endmodule

/* File: include/rtc_pkg.sv */
// Constants, register map and state encoding of the clock control register bank.
// Summary of operation
// - Oscillator-stop flag is held clear while the flag-mask bit is set.
// - Power-fail enable bit gates the power-fail flag onto the interrupt pin.
// - Temperature-ready enable bit gates the measurement-ready flag onto the interrupt.
// - Countdown enable bit gates the timer-expiry flag onto the interrupt.
// - Second alarm enable bit gates the second alarm flag onto the interrupt.
// - First alarm enable bit gates the first alarm flag onto the interrupt.
// - Software reset holds logic and user registers in reset and stops the oscillator.
// - Retention bit selects data-retention mode; it resets to zero.
// - Bus timeout enable bit resets to one and arms the bus timeout.
// - Oscillator enable bit resets to one and runs the oscillator.
// - Raw clock enable bit drives the raw clock pin or floats it.
// - Raw frequency codes 0 to 7 give 1.0032 Hz doubling to 128.4179 Hz.
// - Raw frequency codes 8 and above give full oscillator rate; reset code 8.
// - Square-wave codes 0 to 5 give 1 to 32 Hz; 6 and 7 give 32 Hz.
// - Interrupt asserts when a status flag and its enable are both set.
// - Reading the status register clears its latched flags.
// - Oscillator-stop flag never drives the interrupt pin.
package rtc_pkg;

  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_INT_EN     = 8'h01;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h02;
  localparam logic [7:0] ADDR_CORE_CFG   = 8'h03;
  localparam logic [7:0] ADDR_CLK_CFG    = 8'h04;

  localparam int BIT_OSC_FLAG    = 6;
  localparam int BIT_POWER_FAIL_FLAG       = 5;
  localparam int BIT_TEMP        = 3;
  localparam int BIT_CNTDN       = 2;
  localparam int BIT_ALM2        = 1;
  localparam int BIT_ALM1        = 0;
  localparam int BIT_SOFT_RESET  = 0;
  localparam int BIT_RETENTION   = 4;
  localparam int BIT_I2C_TIMEOUT = 3;
  localparam int BIT_OSC_EN      = 1;
  localparam int BIT_RAW_EN      = 7;
  localparam int RAW_FREQ_MSB    = 6;
  localparam int RAW_FREQ_LSB    = 3;
  localparam int SQW_FREQ_MSB    = 2;
  localparam int SQW_FREQ_LSB    = 0;

  localparam logic [7:0] INT_EN_MASK    = 8'h6f;
  localparam logic [7:0] CORE_CFG_MASK  = 8'h1b;
  localparam logic [7:0] IRQ_SRC_MASK   = 8'h2f;
  localparam logic [7:0] STATUS_FLAGS   = 8'h6f;
  localparam logic [7:0] INT_EN_RST     = 8'h00;
  localparam logic [7:0] CORE_CFG_RST   = 8'h0a;
  localparam logic [7:0] CLK_CFG_RST    = 8'h40;
  localparam logic [7:0] STATUS_RST     = 8'h40;

  localparam logic [3:0] RAW_FULL_RATE_CODE = 4'h8;
  localparam logic [2:0] SQW_MAX_CODE       = 3'h5;
  localparam int         OSC_HZ             = 32875;
  localparam int         DIV_W              = 15;
  localparam int         BYTE_BITS          = 8;

  localparam int CLK_HZ         = 100_000_000;
  localparam int I2C_TIMEOUT_MS = 35;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_RX   = 6'h08,
    ST_TX   = 6'h10,
    ST_RACK = 6'h20
  } rtc_i2c_state_t;

endpackage

/* File: tb/rtc_ctl_checker.sv */
// Port-level concurrent checks for the clock control register bank.
`timescale 1ns/1ps
module rtc_ctl_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_osc_clk,
  input wire logic i_power_fail,
  input wire logic i_temp_ready,
  input wire logic i_countdown_expired,
  input wire logic i_alarm_two,
  input wire logic i_alarm_one,
  input wire logic o_int_n,
  input wire logic o_raw_clock_pin,
  input wire logic o_raw_clock_oe,
  input wire logic o_square_wave_pin,
  input wire logic o_retention_mode,
  input wire logic o_i2c_timeout_en,
  input wire logic o_oscillator_en,
  input wire logic o_digital_reset
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  logic [2:0]  osc_sync_q;
  logic [15:0] osc_edges_q;
  logic        sqw_last_q;

  always_ff @(posedge i_clk_sys) begin
    osc_sync_q <= {osc_sync_q[1:0], i_osc_clk};
  end

  // Oscillator edges since the square wave last changed; a slower wave only counts higher.
  always_ff @(posedge i_clk_sys) begin
    sqw_last_q <= o_square_wave_pin;
    if (!i_rst_n || sqw_last_q != o_square_wave_pin) begin
      osc_edges_q <= 16'h0000;
    end else if (osc_sync_q[1] && !osc_sync_q[2] && osc_edges_q != 16'hffff) begin
      osc_edges_q <= osc_edges_q + 16'h0001;
    end
  end

  a_reset_core_cfg: assert property (
    $rose(i_rst_n) |-> o_i2c_timeout_en && !o_retention_mode)
    else $error("Core configuration outputs wrong after reset.");
  a_reset_raw_hiz: assert property (
    $rose(i_rst_n) |-> !o_raw_clock_oe && !o_raw_clock_pin)
    else $error("Raw clock pin driven after reset.");
  a_reset_irq_idle: assert property (
    $rose(i_rst_n) |-> o_int_n && !o_sda_oe)
    else $error("Interrupt or data pin active after reset.");
  a_osc_en_release: assert property (
    $rose(i_rst_n) |=> o_oscillator_en)
    else $error("Oscillator not enabled after reset.");
  a_soft_stops_osc: assert property (
    o_digital_reset |=> !o_oscillator_en)
    else $error("Oscillator runs during soft reset.");
  a_soft_holds_cfg: assert property (
    o_digital_reset [*3] |-> !o_retention_mode && o_i2c_timeout_en && !o_raw_clock_oe && o_int_n)
    else $error("Registers not held during soft reset.");
  a_osc_back_on: assert property (
    $fell(o_digital_reset) |-> ##[0:2] o_oscillator_en)
    else $error("Oscillator not restored after soft reset.");
  a_pins_stop_low: assert property (
    !o_oscillator_en [*4] |-> !o_raw_clock_pin && !o_square_wave_pin)
    else $error("Clock outputs run with oscillator stopped.");
  a_sqw_half_period: assert property (
    $rose(o_square_wave_pin) |-> osc_edges_q >= 16'h01f4)
    else $error("Square wave faster than its highest rate.");
endmodule

bind rtc_ctl_top rtc_ctl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_rtc_ctl_checker (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .i_osc_clk(i_osc_clk), .i_power_fail(i_power_fail),
  .i_temp_ready(i_temp_ready), .i_countdown_expired(i_countdown_expired),
  .i_alarm_two(i_alarm_two), .i_alarm_one(i_alarm_one), .o_int_n(o_int_n),
  .o_raw_clock_pin(o_raw_clock_pin), .o_raw_clock_oe(o_raw_clock_oe),
  .o_square_wave_pin(o_square_wave_pin), .o_retention_mode(o_retention_mode),
  .o_i2c_timeout_en(o_i2c_timeout_en), .o_oscillator_en(o_oscillator_en),
  .o_digital_reset(o_digital_reset)
);

/* File: tb/rtc_ctl_top_bench.sv */
// Self-checking bench for the clock control register bank.
`timescale 1ns/1ps
module rtc_ctl_top_bench
  import rtc_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2a;
  localparam logic [7:0] DEV_W = {DEV, 1'b0};
  logic       clk_sys, rst_n, osc_clk, host_scl, host_sda, dev_sda, sda_oe, sda_line;
  logic       int_n, raw_pin, raw_oe, sqw_pin, ret_mode, tmo_en, osc_en, dig_rst;
  logic [4:0] src;
  int         compares = 0;
  int         miscompares = 0;
  int         c, b;
  logic       ack_bit;

  // Open drain with a pull-up: low only when some party pulls it.
  assign sda_line = host_sda & (sda_oe ? dev_sda : 1'b1);

  rtc_host_model i_rtc_host_model (
    .i_clk_sys(clk_sys), .i_sda(sda_line), .o_scl(host_scl), .o_sda(host_sda)
  );
  rtc_ctl_top #(.DEV_ADDR(DEV), .TIMEOUT_CYCLES(200)) i_rtc_ctl_top (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_scl(host_scl), .i_sda(sda_line),
    .o_sda(dev_sda), .o_sda_oe(sda_oe), .i_osc_clk(osc_clk), .i_power_fail(src[4]),
    .i_temp_ready(src[3]), .i_countdown_expired(src[2]), .i_alarm_two(src[1]),
    .i_alarm_one(src[0]), .o_int_n(int_n), .o_raw_clock_pin(raw_pin),
    .o_raw_clock_oe(raw_oe), .o_square_wave_pin(sqw_pin), .o_retention_mode(ret_mode),
    .o_i2c_timeout_en(tmo_en), .o_oscillator_en(osc_en), .o_digital_reset(dig_rst)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #62.5 osc_clk = ~osc_clk;
  end
  initial begin
    #950_000;
    miscompares++;
    results();
  end

  task automatic results();
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_span(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    i_rtc_host_model.byte_io(d, 1'b1, r, k);
    check_val({7'h00, k}, 8'h00);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    i_rtc_host_model.start();
    send({DEV, 1'b0});
    send(a);
    send(d);
    i_rtc_host_model.stop();
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic       k;
    i_rtc_host_model.start();
    send({DEV, 1'b0});
    send(a);
    i_rtc_host_model.start();
    send({DEV, 1'b1});
    i_rtc_host_model.byte_io(8'hff, 1'b1, r, k);
    i_rtc_host_model.stop();
    check_val(r, e);
  endtask

  task automatic pulse(input logic [4:0] m);
    src = m;
    i_rtc_host_model.step(4);
    src = 5'h00;
    i_rtc_host_model.step(6);
  endtask

  task automatic toggles(input logic sq, input int n, output int cnt);
    logic p, v;
    cnt = 0;
    p = sq ? sqw_pin : raw_pin;
    repeat (n) begin
      i_rtc_host_model.step(1);
      v = sq ? sqw_pin : raw_pin;
      if (v !== p) cnt++;
      p = v;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    src = 5'h00;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    i_rtc_host_model.step(4);
    check_val({4'h0, ret_mode, tmo_en, raw_oe, int_n}, 8'h05);
    reg_read(ADDR_STATUS, STATUS_RST);
    reg_read(ADDR_INT_EN, INT_EN_RST);
    reg_read(ADDR_SOFT_RESET, 8'h00);
    reg_read(ADDR_CORE_CFG, CORE_CFG_RST);
    reg_read(ADDR_CLK_CFG, CLK_CFG_RST);
    reg_write(ADDR_INT_EN, 8'hff);
    reg_read(ADDR_INT_EN, 8'h6f);
    reg_write(ADDR_CORE_CFG, 8'h12);
    reg_read(ADDR_CORE_CFG, 8'h12);
    check_val({6'h00, ret_mode, tmo_en}, 8'h02);
    for (int i = 0; i < 5; i++) begin
      b = (i == 4) ? 5 : i;
      reg_write(ADDR_INT_EN, 8'h01 << b);
      pulse(5'h1f ^ (5'h01 << i));
      check_val({7'h00, int_n}, 8'h01);
      pulse(5'h01 << i);
      check_val({7'h00, int_n}, 8'h00);
      reg_read(ADDR_STATUS, 8'h2f);
      check_val({7'h00, int_n}, 8'h01);
    end
    reg_write(ADDR_CLK_CFG, 8'hc7);
    check_val({7'h00, raw_oe}, 8'h01);
    toggles(1'b0, 1000, c);
    check_span(c, 150, 170);
    toggles(1'b1, 7000, c);
    check_span(c, 1, 2);
    reg_write(ADDR_CLK_CFG, 8'hb8);
    toggles(1'b0, 4000, c);
    check_span(c, 2, 3);
    reg_write(ADDR_CLK_CFG, 8'hf8);
    toggles(1'b0, 1000, c);
    check_span(c, 150, 170);
    reg_write(ADDR_INT_EN, 8'h2f);
    reg_write(ADDR_CORE_CFG, 8'h10);
    check_val({7'h00, osc_en}, 8'h00);
    toggles(1'b0, 500, c);
    check_span(c, 0, 0);
    check_val({6'h00, raw_pin, sqw_pin}, 8'h00);
    check_val({7'h00, int_n}, 8'h01);
    reg_read(ADDR_STATUS, 8'h40);
    reg_write(ADDR_INT_EN, 8'h40);
    reg_read(ADDR_STATUS, 8'h00);
    reg_write(ADDR_CORE_CFG, 8'h12);
    reg_write(ADDR_SOFT_RESET, 8'h01);
    check_val({6'h00, dig_rst, osc_en}, 8'h02);
    reg_write(ADDR_INT_EN, 8'h2f);
    reg_read(ADDR_INT_EN, 8'h00);
    reg_read(ADDR_STATUS, 8'h40);
    reg_read(ADDR_SOFT_RESET, 8'h01);
    reg_write(ADDR_SOFT_RESET, 8'h00);
    reg_read(ADDR_CORE_CFG, CORE_CFG_RST);
    check_val({5'h00, ret_mode, tmo_en, raw_oe}, 8'h02);
    check_val({7'h00, osc_en}, 8'h01);
    // Stall with the clock low during an acknowledge; the timeout must release SDA.
    i_rtc_host_model.start();
    for (int i = 7; i >= 0; i--) i_rtc_host_model.clock_bit(DEV_W[i], ack_bit);
    check_val({7'h00, sda_oe}, 8'h01);
    i_rtc_host_model.step(250);
    check_val({7'h00, sda_oe}, 8'h00);
    i_rtc_host_model.stop();
    results();
  end
endmodule

/* File: tb/rtc_host_model.sv */
// Serial bus master model standing for the host microcontroller.
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // Every phase spans at least 12 clocks so the device synchronisers see each level.
  task automatic start();
    o_sda = 1'b1;
    step(12);
    o_scl = 1'b1;
    step(12);
    o_sda = 1'b0;
    step(12);
    o_scl = 1'b0;
    step(12);
  endtask

  task automatic stop();
    o_sda = 1'b0;
    step(12);
    o_scl = 1'b1;
    step(12);
    o_sda = 1'b1;
    step(25);
  endtask

  task automatic clock_bit(input logic b, output logic r);
    o_sda = b;
    step(12);
    o_scl = 1'b1;
    step(12);
    r = i_sda;
    step(13);
    o_scl = 1'b0;
    step(13);
  endtask

  // Eight data bits MSB first, then the acknowledge bit; a 1 releases the line.
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r,
                         output logic k);
    logic [8:0] v;
    logic [8:0] q;
    v = {d, a};
    for (int i = 8; i >= 0; i--) clock_bit(v[i], q[i]);
    r = q[8:1];
    k = q[0];
  endtask
endmodule
